// ### verilog/dvram_cfg.svh
// Register offsets, field positions, reset values and timing constants of the volume ramp block
`ifndef DVRAM_CFG_SVH
`define DVRAM_CFG_SVH

// Register offsets
`define DVRAM_OFS_VOLUME 8'h4C
`define DVRAM_OFS_NORMAL 8'h4E
`define DVRAM_OFS_EMERG 8'h4F
`define DVRAM_OFS_ZMUTE 8'h50
`define DVRAM_OFS_ZRUN 8'h51
`define DVRAM_OFS_STATUS 8'h60
`define DVRAM_OFS_GAIN_L 8'h61
`define DVRAM_OFS_GAIN_R 8'h62

// Reset values
`define DVRAM_RST_VOLUME 8'h30
`define DVRAM_RST_NORMAL 8'h33
`define DVRAM_RST_EMERG 8'h30
`define DVRAM_RST_ZMUTE 8'h07
`define DVRAM_RST_ZRUN 8'h00

// Fields of the ramp configuration registers
`define DVRAM_DN_SPEED 7:6
`define DVRAM_DN_STEP 5:4
`define DVRAM_UP_SPEED 3:2
`define DVRAM_UP_STEP 1:0

// Fields of the zero-signal mute registers
`define DVRAM_AM_LEFT_EN 0
`define DVRAM_AM_RIGHT_EN 1
`define DVRAM_AM_LINK 2
`define DVRAM_ZRUN_LEFT 6:4
`define DVRAM_ZRUN_RIGHT 2:0

// Status register bits
`define DVRAM_ST_MUTE_L 0
`define DVRAM_ST_MUTE_R 1
`define DVRAM_ST_EMERG 2
`define DVRAM_ST_BUSY_L 3
`define DVRAM_ST_BUSY_R 4

// Volume codes: 0.5 dB per code, 0x30 is 0 dB
`define DVRAM_CODE_ZERO_DB 8'h30
`define DVRAM_CODE_FLOOR 8'hFE
`define DVRAM_CODE_MUTE 8'hFF

// Ramp speed and step codes
`define DVRAM_SPEED_EVERY1 2'h0
`define DVRAM_SPEED_EVERY2 2'h1
`define DVRAM_SPEED_EVERY4 2'h2
`define DVRAM_SPEED_INSTANT 2'h3
`define DVRAM_STEP_CODE_4DB 2'h0
`define DVRAM_STEP_CODE_2DB 2'h1
`define DVRAM_STEP_CODE_1DB 2'h2
`define DVRAM_STEP_4DB 8'h08
`define DVRAM_STEP_2DB 8'h04
`define DVRAM_STEP_1DB 8'h02
`define DVRAM_STEP_HALF_DB 8'h01
`define DVRAM_LAST_EVERY1 2'h0
`define DVRAM_LAST_EVERY2 2'h1
`define DVRAM_LAST_EVERY4 2'h3

// Zero-run lengths in units of 0.1 ms at the reference rate
`define DVRAM_ZRUN_T0 64'd115
`define DVRAM_ZRUN_T1 64'd530
`define DVRAM_ZRUN_T2 64'd1065
`define DVRAM_ZRUN_T3 64'd2665
`define DVRAM_ZRUN_T4 64'd5350
`define DVRAM_ZRUN_T5 64'd10650
`define DVRAM_ZRUN_T6 64'd26650
`define DVRAM_ZRUN_T7 64'd53300
`define DVRAM_TENTHS_MS_PER_S 64'd10000

`endif

// ### verilog/dvram_pkg.sv
// Types shared by the volume ramp block
`default_nettype none

package dvram_pkg;

    // Ramp engine state, Gray coded along idle - down - up
    typedef enum logic [1:0] {
        dvram_st_idle = 2'h0,
        dvram_st_down = 2'h1,
        dvram_st_up = 2'h3
    } dvram_state_type;

endpackage

`default_nettype wire

// ### verilog/dvram_sync.sv
// Two flip-flop synchroniser for asynchronous level inputs
`default_nettype none

module dvram_sync #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Asynchronous levels in
    input wire logic [WIDTH-1:0] async_in,
    // Levels in the clock domain
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;

    // First stage is read only by the second stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1_ff <= '0;
            stage2_ff <= '0;
        end else begin
            stage1_ff <= async_in;
            stage2_ff <= stage1_ff;
        end
    end

    assign sync_out = stage2_ff;

endmodule // dvram_sync

`default_nettype wire

// ### verilog/dvram_top.sv
// Digital volume with soft ramps, emergency ramp-down and zero-signal auto-mute
`default_nettype none
`include "dvram_cfg.svh"

module dvram_top
    import dvram_pkg::*;
#(
    parameter int SAMPLE_W = 24,
    parameter int SAMPLE_RATE_HZ = 96000,
    parameter int ZERO_RUN_DIV = 1,
    parameter int ZERO_RUN_W = 20
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Sample stream, one strobe per sample period
    input wire logic sample_valid,
    input wire logic [SAMPLE_W-1:0] left_sample,
    input wire logic [SAMPLE_W-1:0] right_sample,
    // Fault pins, asynchronous
    input wire logic clock_error_in,
    input wire logic power_loss_in,
    // Applied gain and mute state
    output logic [7:0] left_gain_code,
    output logic [7:0] right_gain_code,
    output logic left_muted,
    output logic right_muted,
    output logic emergency_active
);

    // Software registers
    logic [7:0] volume_ff;
    logic [7:0] normal_cfg_ff;
    logic [7:0] emerg_cfg_ff;
    logic [7:0] zmute_cfg_ff;
    logic [7:0] zrun_cfg_ff;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;

    // Fault inputs and channel state
    logic [1:0] fault_sync;
    logic emergency;
    logic [1:0] mute_ff;
    logic [1:0] nxt_mute;
    wire logic [1:0] qualify;
    wire logic [1:0] busy;
    wire logic [15:0] gain_vec;

    // Step size in volume codes for a step field
    function automatic logic [7:0] step_codes(input logic [1:0] code);
        case (code)
            `DVRAM_STEP_CODE_4DB: step_codes = `DVRAM_STEP_4DB;
            `DVRAM_STEP_CODE_2DB: step_codes = `DVRAM_STEP_2DB;
            `DVRAM_STEP_CODE_1DB: step_codes = `DVRAM_STEP_1DB;
            default: step_codes = `DVRAM_STEP_HALF_DB;
        endcase
    endfunction

    // Last count of the sample-period divider for a speed field
    function automatic logic [1:0] interval_last(input logic [1:0] code);
        case (code)
            `DVRAM_SPEED_EVERY1: interval_last = `DVRAM_LAST_EVERY1;
            `DVRAM_SPEED_EVERY2: interval_last = `DVRAM_LAST_EVERY2;
            `DVRAM_SPEED_EVERY4: interval_last = `DVRAM_LAST_EVERY4;
            default: interval_last = `DVRAM_LAST_EVERY1;
        endcase
    endfunction

    // Zero samples needed before a channel qualifies, rounded up
    function automatic logic [ZERO_RUN_W-1:0] zero_run_limit(input logic [2:0] code);
        logic [63:0] tenths;
        logic [63:0] den;
        logic [63:0] samples;
        tenths = `DVRAM_ZRUN_T0;
        case (code)
            3'h0: tenths = `DVRAM_ZRUN_T0;
            3'h1: tenths = `DVRAM_ZRUN_T1;
            3'h2: tenths = `DVRAM_ZRUN_T2;
            3'h3: tenths = `DVRAM_ZRUN_T3;
            3'h4: tenths = `DVRAM_ZRUN_T4;
            3'h5: tenths = `DVRAM_ZRUN_T5;
            3'h6: tenths = `DVRAM_ZRUN_T6;
            default: tenths = `DVRAM_ZRUN_T7;
        endcase
        den = `DVRAM_TENTHS_MS_PER_S * 64'(ZERO_RUN_DIV);
        samples = (tenths * 64'(SAMPLE_RATE_HZ) + den - 64'd1) / den;
        zero_run_limit = ZERO_RUN_W'(samples);
    endfunction

    // Register writes; reserved bits are stored and read back
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            volume_ff <= `DVRAM_RST_VOLUME;
            normal_cfg_ff <= `DVRAM_RST_NORMAL;
            emerg_cfg_ff <= `DVRAM_RST_EMERG;
            zmute_cfg_ff <= `DVRAM_RST_ZMUTE;
            zrun_cfg_ff <= `DVRAM_RST_ZRUN;
        end else if (reg_wr) begin
            case (reg_addr)
                `DVRAM_OFS_VOLUME: volume_ff <= reg_wdata;
                `DVRAM_OFS_NORMAL: normal_cfg_ff <= reg_wdata;
                `DVRAM_OFS_EMERG: emerg_cfg_ff <= reg_wdata;
                `DVRAM_OFS_ZMUTE: zmute_cfg_ff <= reg_wdata;
                `DVRAM_OFS_ZRUN: zrun_cfg_ff <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Read decode; unmapped offsets read zero
    always_comb begin
        nxt_rdata = 8'h00;
        case (reg_addr)
            `DVRAM_OFS_VOLUME: nxt_rdata = volume_ff;
            `DVRAM_OFS_NORMAL: nxt_rdata = normal_cfg_ff;
            `DVRAM_OFS_EMERG: nxt_rdata = emerg_cfg_ff;
            `DVRAM_OFS_ZMUTE: nxt_rdata = zmute_cfg_ff;
            `DVRAM_OFS_ZRUN: nxt_rdata = zrun_cfg_ff;
            `DVRAM_OFS_STATUS: begin
                nxt_rdata[`DVRAM_ST_MUTE_L] = mute_ff[0];
                nxt_rdata[`DVRAM_ST_MUTE_R] = mute_ff[1];
                nxt_rdata[`DVRAM_ST_EMERG] = emergency;
                nxt_rdata[`DVRAM_ST_BUSY_L] = busy[0];
                nxt_rdata[`DVRAM_ST_BUSY_R] = busy[1];
            end
            `DVRAM_OFS_GAIN_L: nxt_rdata = gain_vec[7:0];
            `DVRAM_OFS_GAIN_R: nxt_rdata = gain_vec[15:8];
            default: nxt_rdata = 8'h00;
        endcase
    end

    // Read data stand only in the cycle after the read strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign reg_rdata = rdata_ff;

    // Fault pins cross into the clock domain
    dvram_sync #(
        .WIDTH(2)
    ) u_fault_sync (
        .clk(clk),
        .rst(rst),
        .async_in({power_loss_in, clock_error_in}),
        .sync_out(fault_sync)
    );

    // Either fault selects the emergency ramp-down
    assign emergency = |fault_sync;

    // Combine the per-channel conditions into mute decisions
    always_comb begin
        if (zmute_cfg_ff[`DVRAM_AM_LINK]) begin
            nxt_mute = {2{&qualify}};
        end else begin
            nxt_mute = qualify;
        end
    end

    // Registered mute decision
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mute_ff <= 2'h0;
        end else begin
            mute_ff <= nxt_mute;
        end
    end

    // One zero detector and one ramp engine per channel
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        logic [SAMPLE_W-1:0] sample;
        logic [2:0] zrun_code;
        logic enable;
        logic [ZERO_RUN_W-1:0] limit;
        logic [ZERO_RUN_W-1:0] zrun_cnt_ff;
        logic [7:0] target;
        logic [7:0] gain_ff;
        logic [1:0] div_ff;
        logic go_down;
        logic [1:0] speed;
        logic [7:0] step;
        logic [7:0] distance;
        logic [7:0] nxt_gain;
        dvram_state_type state_ff;
        dvram_state_type nxt_state;

        // Channel inputs and settings
        assign sample = (ch == 0) ? left_sample : right_sample;
        assign zrun_code = (ch == 0) ? zrun_cfg_ff[`DVRAM_ZRUN_LEFT] :
            zrun_cfg_ff[`DVRAM_ZRUN_RIGHT];
        assign enable = (ch == 0) ? zmute_cfg_ff[`DVRAM_AM_LEFT_EN] :
            zmute_cfg_ff[`DVRAM_AM_RIGHT_EN];
        assign limit = zero_run_limit(zrun_code);

        // Count consecutive zero samples, saturating at the limit
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                zrun_cnt_ff <= '0;
            end else if (sample_valid) begin
                if (sample != '0) begin
                    zrun_cnt_ff <= '0;
                end else if (zrun_cnt_ff < limit) begin
                    zrun_cnt_ff <= zrun_cnt_ff + ZERO_RUN_W'(1);
                end
            end
        end

        assign qualify[ch] = enable && (zrun_cnt_ff >= limit);

        // Fault or auto-mute drives the target to mute, else the shared volume
        assign target = (emergency || mute_ff[ch]) ? `DVRAM_CODE_MUTE :
            volume_ff;

        // Direction, speed and step of the next update
        always_comb begin
            go_down = target > gain_ff;
            if (go_down && emergency) begin
                speed = emerg_cfg_ff[`DVRAM_DN_SPEED];
                step = step_codes(emerg_cfg_ff[`DVRAM_DN_STEP]);
            end else if (go_down) begin
                speed = normal_cfg_ff[`DVRAM_DN_SPEED];
                step = step_codes(normal_cfg_ff[`DVRAM_DN_STEP]);
            end else begin
                speed = normal_cfg_ff[`DVRAM_UP_SPEED];
                step = step_codes(normal_cfg_ff[`DVRAM_UP_STEP]);
            end
            distance = go_down ? (target - gain_ff) : (gain_ff - target);
            if (distance <= step) begin
                nxt_gain = target;
            end else if (go_down) begin
                nxt_gain = gain_ff + step;
            end else begin
                nxt_gain = gain_ff - step;
            end
        end

        // Apply updates on the sample-period divider, or at once when instant
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                gain_ff <= `DVRAM_RST_VOLUME;
                div_ff <= 2'h0;
            end else if (gain_ff == target) begin
                div_ff <= 2'h0;
            end else if (speed == `DVRAM_SPEED_INSTANT) begin
                gain_ff <= target;
                div_ff <= 2'h0;
            end else if (sample_valid) begin
                if (div_ff >= interval_last(speed)) begin
                    gain_ff <= nxt_gain;
                    div_ff <= 2'h0;
                end else begin
                    div_ff <= div_ff + 2'h1;
                end
            end
        end

        // Ramp state for status
        always_comb begin
            if (gain_ff == target) begin
                nxt_state = dvram_st_idle;
            end else if (go_down) begin
                nxt_state = dvram_st_down;
            end else begin
                nxt_state = dvram_st_up;
            end
        end

        // State register
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                state_ff <= dvram_st_idle;
            end else begin
                state_ff <= nxt_state;
            end
        end

        // Export channel results
        assign busy[ch] = (state_ff != dvram_st_idle);
        assign gain_vec[ch*8 +: 8] = gain_ff;
    end

    // Output drive
    assign left_gain_code = gain_vec[7:0];
    assign right_gain_code = gain_vec[15:8];
    assign left_muted = mute_ff[0];
    assign right_muted = mute_ff[1];
    assign emergency_active = emergency;

endmodule // dvram_top

`default_nettype wire

// ### testbench/dvram_checker.sv
// Assertion checker for the volume ramp block
`default_nettype none
`include "dvram_cfg.svh"

module dvram_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    // Sample tick and fault pins
    input wire logic sample_valid,
    input wire logic clock_error_in,
    input wire logic power_loss_in,
    // Applied gain and mute state
    input wire logic [7:0] left_gain_code,
    input wire logic [7:0] right_gain_code,
    input wire logic left_muted,
    input wire logic right_muted,
    input wire logic emergency_active
);
    logic [7:0] nrm_ff;
    logic [7:0] em_ff;
    logic [7:0] zm_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Step in codes for a step field: 8, 4, 2, 1
    function automatic logic [7:0] step_of(input logic [1:0] c);
        return 8'h08 >> c;
    endfunction

    // Shadow copies of the ramp and mute settings
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nrm_ff <= `DVRAM_RST_NORMAL;
            em_ff <= `DVRAM_RST_EMERG;
            zm_ff <= `DVRAM_RST_ZMUTE;
        end else if (reg_wr) begin
            if (reg_addr == `DVRAM_OFS_NORMAL) nrm_ff <= reg_wdata;
            if (reg_addr == `DVRAM_OFS_EMERG) em_ff <= reg_wdata;
            if (reg_addr == `DVRAM_OFS_ZMUTE) zm_ff <= reg_wdata;
        end
    end

    // Fault pin held, or released, over two edges
    sequence fault_held;
        (clock_error_in || power_loss_in) [*2];
    endsequence
    sequence fault_gone;
        (!clock_error_in && !power_loss_in) [*2];
    endsequence

    a_fault_sync: assert property (fault_held |=> emergency_active)
        else $error("fault pin not seen after two edges");
    a_fault_clear: assert property (fault_gone |=> !emergency_active)
        else $error("emergency flag stuck after fault removal");
    a_gain_quiet: assert property ($changed(left_gain_code) && !$past(sample_valid)
        |-> nrm_ff[7:6] == 2'h3 || nrm_ff[3:2] == 2'h3 || em_ff[7:6] == 2'h3)
        else $error("gain moved without a sample tick");
    a_down_step: assert property (!emergency_active && !$past(emergency_active)
        && nrm_ff[7:6] != 2'h3 && right_gain_code > $past(right_gain_code)
        |-> right_gain_code - $past(right_gain_code) <= step_of(nrm_ff[5:4]))
        else $error("down step too large");
    a_up_step: assert property (!emergency_active && nrm_ff[3:2] != 2'h3
        && left_gain_code < $past(left_gain_code)
        |-> $past(left_gain_code) - left_gain_code <= step_of(nrm_ff[1:0]))
        else $error("up step too large");
    a_emerg_step: assert property (emergency_active && $past(emergency_active)
        && em_ff[7:6] != 2'h3 && left_gain_code > $past(left_gain_code)
        |-> left_gain_code - $past(left_gain_code) <= step_of(em_ff[5:4]))
        else $error("emergency step too large");
    a_emerg_instant: assert property (emergency_active && em_ff[7:6] == 2'h3
        |-> ##[0:2] left_gain_code == `DVRAM_CODE_MUTE)
        else $error("instant emergency mute missing");
    a_link_pair: assert property (zm_ff[2] && $past(zm_ff[2]) |-> left_muted == right_muted)
        else $error("linked channels muted apart");
    a_left_gate: assert property (!zm_ff[0] && !$past(zm_ff[0]) |-> !left_muted)
        else $error("left muted while disabled");
    a_right_gate: assert property (!zm_ff[1] && !$past(zm_ff[1]) |-> !right_muted)
        else $error("right muted while disabled");
endmodule // dvram_checker

bind dvram_top dvram_checker u_checker (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .sample_valid, .clock_error_in, .power_loss_in, .left_gain_code, .right_gain_code,
    .left_muted, .right_muted, .emergency_active);

`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench for the volume ramp block
`default_nettype none
`include "dvram_cfg.svh"

module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, sample_valid = 1'b0;
    logic clock_error_in = 1'b0, power_loss_in = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, st, e;
    logic [7:0] left_gain_code, right_gain_code;
    logic [23:0] left_sample = 24'h000001, right_sample = 24'h000001;
    logic left_muted, right_muted, emergency_active;
    int n_fail = 0, tests_run = 0, s;

    // Clock and device
    always #10 clk = ~clk;
    dvram_top #(.ZERO_RUN_DIV(1000)) dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .sample_valid, .left_sample, .right_sample, .clock_error_in,
        .power_loss_in, .left_gain_code, .right_gain_code, .left_muted, .right_muted,
        .emergency_active);

    // Compare, bus cycles and sample ticks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            sample_valid <= 1'b1;
            @(posedge clk);
            sample_valid <= 1'b0;
        end
        #1;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic g(input logic [7:0] x);
        chk(left_gain_code, x);
        chk(right_gain_code, x);
    endtask
    task automatic mt(input logic [1:0] m);
        chk({6'h00, right_muted, left_muted}, {6'h00, m});
    endtask
    task automatic summarize();
        if (n_fail == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Guard against a hang
    initial begin
        #200000;
        n_fail++;
        summarize();
    end

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        // Reset values and an unmapped read
        rd(`DVRAM_OFS_VOLUME, `DVRAM_RST_VOLUME);
        rd(`DVRAM_OFS_NORMAL, `DVRAM_RST_NORMAL);
        rd(`DVRAM_OFS_EMERG, `DVRAM_RST_EMERG);
        rd(`DVRAM_OFS_ZMUTE, `DVRAM_RST_ZMUTE);
        rd(`DVRAM_OFS_ZRUN, `DVRAM_RST_ZRUN);
        rd(8'h77, 8'h00);
        // Status is read-only and idle after reset
        wr(`DVRAM_OFS_STATUS, 8'hFF);
        rd(`DVRAM_OFS_STATUS, 8'h00);
        g(`DVRAM_CODE_ZERO_DB);
        // Default half dB ramp down and back up
        wr(`DVRAM_OFS_VOLUME, 8'h34);
        for (s = 1; s < 6; s++) begin
            tick(1);
            g(8'h30 + ((s > 4) ? 8'h04 : s[7:0]));
        end
        wr(`DVRAM_OFS_VOLUME, 8'h30);
        tick(4);
        g(8'h30);
        // Every step code, with the last step clamped for the 4 dB and 2 dB codes
        for (s = 0; s < 4; s++) begin
            wr(`DVRAM_OFS_NORMAL, {2'h0, s[1:0], 2'h0, s[1:0]});
            wr(`DVRAM_OFS_VOLUME, 8'h3A);
            st = 8'h08 >> s;
            e = (st > 8'h05) ? 8'h3A : 8'h30 + {st[6:0], 1'b0};
            tick(1);
            g(8'h30 + st);
            tick(1);
            g(e);
            tick(8);
            g(8'h3A);
            wr(`DVRAM_OFS_VOLUME, 8'h30);
            tick(1);
            g(8'h3A - st);
            tick(10);
            g(8'h30);
        end
        // Update intervals of 1, 2 and 4 sample periods
        for (s = 0; s < 3; s++) begin
            wr(`DVRAM_OFS_NORMAL, {s[1:0], 2'h3, s[1:0], 2'h3});
            wr(`DVRAM_OFS_VOLUME, 8'h31);
            tick((1 << s) - 1);
            g(8'h30);
            tick(1);
            g(8'h31);
            wr(`DVRAM_OFS_VOLUME, 8'h30);
            tick((1 << s) - 1);
            g(8'h31);
            tick(1);
            g(8'h30);
        end
        // Instant changes, floor and mute codes
        wr(`DVRAM_OFS_NORMAL, 8'hFF);
        wr(`DVRAM_OFS_VOLUME, 8'h50);
        idle(2);
        g(8'h50);
        wr(`DVRAM_OFS_VOLUME, `DVRAM_CODE_FLOOR);
        idle(2);
        g(`DVRAM_CODE_FLOOR);
        rd(`DVRAM_OFS_GAIN_L, `DVRAM_CODE_FLOOR);
        wr(`DVRAM_OFS_VOLUME, `DVRAM_CODE_MUTE);
        idle(2);
        g(`DVRAM_CODE_MUTE);
        wr(`DVRAM_OFS_VOLUME, 8'h30);
        idle(2);
        g(8'h30);
        // Power loss ramp: every 2 periods, half dB
        wr(`DVRAM_OFS_NORMAL, 8'h3F);
        wr(`DVRAM_OFS_EMERG, 8'h70);
        power_loss_in <= 1'b1;
        idle(3);
        chk({7'h00, emergency_active}, 8'h01);
        rd(`DVRAM_OFS_STATUS, 8'h1C);
        tick(1);
        g(8'h30);
        tick(1);
        g(8'h31);
        @(posedge clk);
        power_loss_in <= 1'b0;
        idle(4);
        g(8'h30);
        // Clock error ramp: 4 dB steps, then instant mute
        wr(`DVRAM_OFS_EMERG, 8'h00);
        clock_error_in <= 1'b1;
        idle(3);
        tick(1);
        g(8'h38);
        tick(1);
        g(8'h40);
        rd(`DVRAM_OFS_GAIN_R, 8'h40);
        wr(`DVRAM_OFS_EMERG, 8'hC0);
        idle(2);
        g(`DVRAM_CODE_MUTE);
        @(posedge clk);
        clock_error_in <= 1'b0;
        idle(4);
        g(8'h30);
        // Linked auto-mute waits for both channels
        wr(`DVRAM_OFS_ZRUN, 8'h10);
        left_sample <= 24'h000000;
        tick(8);
        mt(2'b00);
        @(posedge clk);
        right_sample <= 24'h000000;
        tick(2);
        idle(1);
        mt(2'b11);
        @(posedge clk);
        left_sample <= 24'h000001;
        tick(1);
        idle(1);
        mt(2'b00);
        // Independent mode and zero-run length boundary
        wr(`DVRAM_OFS_ZMUTE, 8'h03);
        idle(1);
        mt(2'b10);
        @(posedge clk);
        right_sample <= 24'h000001;
        left_sample <= 24'h000000;
        tick(5);
        idle(1);
        mt(2'b00);
        tick(1);
        idle(1);
        mt(2'b01);
        // Per-channel enables
        wr(`DVRAM_OFS_ZMUTE, 8'h02);
        idle(1);
        mt(2'b00);
        @(posedge clk);
        left_sample <= 24'h000001;
        right_sample <= 24'h000000;
        wr(`DVRAM_OFS_ZMUTE, 8'h01);
        tick(3);
        idle(1);
        mt(2'b00);
        summarize();
    end
endmodule // testbench

`default_nettype wire
